// ==== logic/intgrp_cfg.svh ====
`ifndef INTGRP_CFG_SVH
`define INTGRP_CFG_SVH

// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_ENABLE 12'h004
`define OFS_BP_GRP0 12'h008
`define OFS_BP_GRP1 12'h00C
`define OFS_PRIO_MASK 12'h010
`define OFS_STATUS 12'h014
`define OFS_ACK_GRP0 12'h020
`define OFS_ACK_GRP1 12'h024
`define OFS_DONE_GRP0 12'h028
`define OFS_DONE_GRP1 12'h02C
`define OFS_HIGHEST_GRP0 12'h030
`define OFS_HIGHEST_GRP1 12'h034
`define OFS_SGI_REQUEST 12'h038
`define OFS_NS_ACCESS 12'h03C
`define OFS_PRIVATE_SELECT 12'h080
`define OFS_PRIVATE_MODIFIER 12'h084
// Shared arrays: word n at base + 4n, n >= 1; paddr[11:7] selects the array
`define SPI_SELECT_REGION 5'h02
`define SPI_MODIFIER_REGION 5'h04
`define SPI_WORDS_DEFAULT 4

// Control register fields
`define CTRL_SEC_DISABLE 0
`define CTRL_COMMON_BP 1
`define CTRL_COMMON_BP_NS 2
`define CTRL_COMMON_BP_S 3
`define CTRL_SYSREG_EN 4
`define CTRL_TOP_32BIT 5
`define CTRL_AFFINITY_EN 6
`define CTRL_RESET 32'h0000_0050

// Enable register fields
`define EN_GRP0 0
`define EN_GRP1_S 1
`define EN_GRP1_NS 2
`define ENABLE_RESET 32'h0000_0000

// Other reset values and constants
`define BP_RESET 3'h2
`define PRIO_MASK_RESET 8'h00
`define NS_ACCESS_RESET 2'h0
`define SPURIOUS_ID 10'h3FF
`define PRIVATE_ID_LIMIT 10'h020
`define TOP_LEVEL 2'h3

`endif

// ==== logic/intgrp_pkg.sv ====
package intgrp_pkg;

  typedef enum logic [1:0] {
    GROUP_0,
    GROUP_1_SECURE,
    GROUP_1_NONSECURE
  } group_type;

  typedef struct packed {
    logic valid;
    logic active_pending;
    logic locality;
    logic [9:0] id;
    logic [7:0] prio_level;
  } pending_type;

  typedef struct packed {
    logic [1:0] level;
    logic nonsecure;
  } context_type;

  typedef struct packed {
    logic valid;
    group_type grp;
    logic [9:0] id;
  } event_type;

endpackage

// ==== logic/interrupt_group_fiq_irq_select.sv ====
// Operation
// R1: Two security states: every interrupt is group 0, secure group 1 or non-secure group 1.
// R2: Single security state: every interrupt is group 0 or group 1.
// R3: Security disable 0 gives both security states and three groups.
// R4: Security disable 1 gives one security state and two groups.
// R5: Shared interrupts take group from shared select/modifier arrays, index above zero.
// R6: Software and private interrupts take group from the index-0 private registers.
// R7: Message locality interrupts are forced to non-secure group 1, or group 1.
// R8: Group 0 has acknowledge, completion, binary point, highest pending, enable.
// R9: Group 1 has banked binary point; enable follows the interrupt's target state.
// R10: Common binary point select makes group 1 use the group 0 binary point.
// R11: Separate common binary point controls for non-secure and secure group 1.
// R12: With two security states group 0 is always secure.
// R13: Security disable 0: software interrupt needs requester state and access control permission.
// R14: Security disable 1: software interrupts ignore the access control register.
// R15: Security state checked on config, acknowledge, priority drop, deactivation only when disable 0.
// R16: Secure group 1 treated as group 0 without top level or sysreg enable.
// R17: Software never routes groups to a processing element of the wrong state.
// R18: Qualifying group 0 interrupt always raises the fast request.
// R19: Group 1 is fast for the other state or at top level, else normal.
// R20: Top level in 32-bit state: secure group 1 normal, non-secure group 1 fast.
// R21: Single security state: group 0 fast, group 1 normal at every level.
// R22: Both request lines are re-evaluated on exception entry or return.
// R23: Group to line mapping applies only with affinity routing enabled.
// R24: An active-and-pending interrupt is never signalled.
// R25: Request lines are levels held while the interrupt stays selected.
`timescale 1ns/1ps
`include "intgrp_cfg.svh"

module interrupt_group_fiq_irq_select #(
  parameter int NUM_SPI_WORDS = `SPI_WORDS_DEFAULT,
  parameter bit HAS_TOP_LEVEL = 1'b1
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Highest pending candidate and running priority
  input wire intgrp_pkg::pending_type pending_in,
  input wire logic [7:0] running_priority,
  // Processing element context
  input wire intgrp_pkg::context_type pe_context,
  input wire logic context_sync,
  // Request lines
  output logic fast_interrupt_request,
  output logic normal_interrupt_request,
  // Events to the state machines outside
  output intgrp_pkg::event_type ack_event,
  output intgrp_pkg::event_type completion_event,
  output intgrp_pkg::event_type sgi_event
);
  import intgrp_pkg::*;

  logic [31:0] ctrl_reg;
  logic [31:0] enable_reg;
  logic [2:0] bp_grp0_reg;
  logic [2:0] bp_grp1_s_reg;
  logic [2:0] bp_grp1_ns_reg;
  logic [7:0] prio_mask_reg;
  logic [1:0] ns_access_reg;
  logic [31:0] private_select_reg;
  logic [31:0] private_modifier_reg;
  logic [31:0] spi_select_reg [1:NUM_SPI_WORDS-1];
  logic [31:0] spi_modifier_reg [1:NUM_SPI_WORDS-1];
  context_type context_reg;
  logic fast_reg;
  logic normal_reg;
  logic [31:0] rdata_reg;
  group_type ack_group_reg;
  event_type ack_reg;
  event_type completion_reg;
  event_type sgi_reg;

  logic security_disable;
  logic nonsecure_req;
  logic ns_blocked;
  logic setup_phase;
  logic write_access;
  logic read_access;
  logic addr_err;
  logic [31:0] rdata_next;
  logic [4:0] word_idx;
  logic spi_word_ok;
  logic raw_select;
  logic raw_modifier;
  logic id_mapped;
  group_type group_raw;
  group_type hp_group;
  logic group_enabled;
  logic use_common_bp;
  logic [2:0] bp_eff;
  logic [7:0] group_mask;
  logic sufficient;
  logic qualify;
  logic to_fast;
  logic at_top;
  logic [9:0] ack0_value;
  logic [9:0] ack1_value;
  logic sgi_allowed;
  group_type sgi_group;

  assign security_disable = ctrl_reg[`CTRL_SEC_DISABLE];
  assign nonsecure_req = pprot[1];
  // Security checks of the requester
  // R15: checks only without disable
  assign ns_blocked = !security_disable && nonsecure_req;
  assign setup_phase = psel && !penable && clk_en;
  assign write_access = psel && penable && clk_en && pwrite && !addr_err;
  assign read_access = psel && penable && clk_en && !pwrite && !addr_err;
  assign word_idx = paddr[6:2];
  assign spi_word_ok = (word_idx != 5'h00) && (int'(word_idx) < NUM_SPI_WORDS);

  assign pready = clk_en;
  assign pslverr = psel && penable && addr_err;
  assign prdata = rdata_reg;
  assign fast_interrupt_request = fast_reg;
  assign normal_interrupt_request = normal_reg;
  assign ack_event = ack_reg;
  assign completion_event = completion_reg;
  assign sgi_event = sgi_reg;

  function automatic group_type classify(input logic sel, input logic modifier, input logic ds);
    group_type g;
    // R2: single state, two groups
    // R4: disable set, group 0 or 1
    if (ds) begin
      g = sel ? GROUP_1_NONSECURE : GROUP_0;
    // R1: three groups with two states
    // R3: disable clear, three groups
    end else if (sel) begin
      g = GROUP_1_NONSECURE;
    end else if (modifier) begin
      g = GROUP_1_SECURE;
    end else begin
      g = GROUP_0;
    end
    return g;
  endfunction

  // Group lookup for the pending candidate
  always_comb begin
    raw_select = 1'b0;
    raw_modifier = 1'b0;
    id_mapped = 1'b0;
    if (pending_in.locality) begin
      id_mapped = 1'b1;
    // R6: private index-0 registers
    end else if (pending_in.id < `PRIVATE_ID_LIMIT) begin
      raw_select = private_select_reg[pending_in.id[4:0]];
      raw_modifier = private_modifier_reg[pending_in.id[4:0]];
      id_mapped = 1'b1;
    // R5: shared arrays above zero
    end else if (int'(pending_in.id[9:5]) < NUM_SPI_WORDS) begin
      raw_select = spi_select_reg[pending_in.id[9:5]][pending_in.id[4:0]];
      raw_modifier = spi_modifier_reg[pending_in.id[9:5]][pending_in.id[4:0]];
      id_mapped = 1'b1;
    end
  end

  always_comb begin
    // R7: locality interrupts forced
    if (pending_in.locality) begin
      group_raw = GROUP_1_NONSECURE;
    end else begin
      group_raw = classify(raw_select, raw_modifier, security_disable);
    end
    hp_group = group_raw;
    // R16: secure group 1 demoted
    if (!security_disable && group_raw == GROUP_1_SECURE
        && (!HAS_TOP_LEVEL || !ctrl_reg[`CTRL_SYSREG_EN])) begin
      hp_group = GROUP_0;
    end
  end

  // Group enable and priority qualification
  always_comb begin
    // R8: group 0 enable
    // R9: target state enable
    case (hp_group)
      GROUP_0: group_enabled = enable_reg[`EN_GRP0];
      GROUP_1_SECURE: group_enabled = enable_reg[`EN_GRP1_S];
      GROUP_1_NONSECURE: group_enabled = enable_reg[`EN_GRP1_NS];
      default: group_enabled = 1'b0;
    endcase
    // R11: per-state common controls
    if (security_disable) begin
      use_common_bp = ctrl_reg[`CTRL_COMMON_BP];
    end else if (hp_group == GROUP_1_SECURE) begin
      use_common_bp = ctrl_reg[`CTRL_COMMON_BP_S];
    end else begin
      use_common_bp = ctrl_reg[`CTRL_COMMON_BP_NS];
    end
    // R10: group 0 point shared
    if (hp_group == GROUP_0 || use_common_bp) begin
      bp_eff = bp_grp0_reg;
    end else if (hp_group == GROUP_1_SECURE) begin
      bp_eff = bp_grp1_s_reg;
    end else begin
      bp_eff = bp_grp1_ns_reg;
    end
    group_mask = 8'(8'hFE << bp_eff);
    sufficient = (pending_in.prio_level < prio_mask_reg)
                 && ((pending_in.prio_level & group_mask) < (running_priority & group_mask));
    // R24: active and pending excluded
    // R23: affinity routing only
    qualify = pending_in.valid && id_mapped && !pending_in.active_pending && sufficient
              && group_enabled && ctrl_reg[`CTRL_AFFINITY_EN];
  end

  // Line selection from the latched context
  always_comb begin
    at_top = HAS_TOP_LEVEL && (context_reg.level == `TOP_LEVEL) && !security_disable;
    // R21: single state mapping
    if (security_disable) begin
      to_fast = (hp_group == GROUP_0);
    // R18: group 0 always fast
    // R12: group 0 is secure
    end else if (hp_group == GROUP_0) begin
      to_fast = 1'b1;
    // R20: 32-bit top level
    end else if (at_top && ctrl_reg[`CTRL_TOP_32BIT]) begin
      to_fast = (hp_group == GROUP_1_NONSECURE);
    // R19: top level is fast
    end else if (at_top) begin
      to_fast = 1'b1;
    // R19: other state is fast
    end else begin
      to_fast = (hp_group == GROUP_1_SECURE) == context_reg.nonsecure;
    end
  end

  // R22: context latched on sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      context_reg <= '{level: 2'h3, nonsecure: 1'b0};
    end else if (clk_en && context_sync) begin
      context_reg <= pe_context;
    end
  end

  // R25: registered level lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_reg <= 1'b0;
      normal_reg <= 1'b0;
    end else if (clk_en) begin
      fast_reg <= qualify && to_fast;
      normal_reg <= qualify && !to_fast;
    end
  end

  // Acknowledge values
  always_comb begin
    ack0_value = `SPURIOUS_ID;
    ack1_value = `SPURIOUS_ID;
    // R15: acknowledge check
    if (qualify && hp_group == GROUP_0 && !ns_blocked) begin
      ack0_value = pending_in.id;
    end
    if (qualify && hp_group != GROUP_0 && !(ns_blocked && hp_group == GROUP_1_SECURE)) begin
      ack1_value = pending_in.id;
    end
  end

  // Read decode and address check
  always_comb begin
    rdata_next = 32'h0000_0000;
    addr_err = 1'b0;
    if (paddr[11:7] == `SPI_SELECT_REGION) begin
      if (spi_word_ok) begin
        rdata_next = spi_select_reg[word_idx];
      end else begin
        addr_err = 1'b1;
      end
    end else if (paddr[11:7] == `SPI_MODIFIER_REGION) begin
      if (spi_word_ok) begin
        rdata_next = spi_modifier_reg[word_idx];
      end else begin
        addr_err = 1'b1;
      end
    end else begin
      case (paddr)
        `OFS_CTRL: rdata_next = ctrl_reg;
        `OFS_ENABLE: rdata_next = enable_reg;
        `OFS_BP_GRP0: rdata_next = {29'h0000_0000, bp_grp0_reg};
        `OFS_BP_GRP1: rdata_next = {29'h0000_0000, nonsecure_req ? bp_grp1_ns_reg : bp_grp1_s_reg};
        `OFS_PRIO_MASK: rdata_next = {24'h00_0000, prio_mask_reg};
        `OFS_STATUS: rdata_next = {24'h00_0000, context_reg, hp_group, qualify, normal_reg, fast_reg};
        `OFS_ACK_GRP0: rdata_next = {22'h00_0000, ack0_value};
        `OFS_ACK_GRP1: rdata_next = {22'h00_0000, ack1_value};
        `OFS_HIGHEST_GRP0: rdata_next = {22'h00_0000,
          (pending_in.valid && id_mapped && hp_group == GROUP_0) ? pending_in.id : `SPURIOUS_ID};
        `OFS_HIGHEST_GRP1: rdata_next = {22'h00_0000,
          (pending_in.valid && id_mapped && hp_group != GROUP_0) ? pending_in.id : `SPURIOUS_ID};
        `OFS_NS_ACCESS: rdata_next = {30'h0000_0000, ns_access_reg};
        `OFS_PRIVATE_SELECT: rdata_next = private_select_reg;
        `OFS_PRIVATE_MODIFIER: rdata_next = private_modifier_reg;
        `OFS_DONE_GRP0, `OFS_DONE_GRP1, `OFS_SGI_REQUEST: rdata_next = 32'h0000_0000;
        default: addr_err = 1'b1;
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
      ack_group_reg <= GROUP_0;
    end else if (setup_phase && !pwrite) begin
      rdata_reg <= rdata_next;
      ack_group_reg <= hp_group;
    end
  end

  // R15: configuration check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
      ns_access_reg <= `NS_ACCESS_RESET;
    end else if (write_access && !ns_blocked) begin
      if (paddr == `OFS_CTRL) begin
        ctrl_reg <= {25'h000_0000, pwdata[6:0]};
      end
      if (paddr == `OFS_NS_ACCESS) begin
        ns_access_reg <= pwdata[1:0];
      end
    end
  end

  // R9: banked group 1 controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= `ENABLE_RESET;
      bp_grp0_reg <= `BP_RESET;
      bp_grp1_s_reg <= `BP_RESET;
      bp_grp1_ns_reg <= `BP_RESET;
      prio_mask_reg <= `PRIO_MASK_RESET;
    end else if (write_access) begin
      case (paddr)
        `OFS_ENABLE: begin
          if (ns_blocked) begin
            enable_reg[`EN_GRP1_NS] <= pwdata[`EN_GRP1_NS];
          end else begin
            enable_reg <= {29'h0000_0000, pwdata[2:0]};
          end
        end
        `OFS_BP_GRP0: begin
          if (!ns_blocked) begin
            bp_grp0_reg <= pwdata[2:0];
          end
        end
        `OFS_BP_GRP1: begin
          if (nonsecure_req) begin
            bp_grp1_ns_reg <= pwdata[2:0];
          end else begin
            bp_grp1_s_reg <= pwdata[2:0];
          end
        end
        `OFS_PRIO_MASK: prio_mask_reg <= pwdata[7:0];
        default: prio_mask_reg <= prio_mask_reg;
      endcase
    end
  end

  // R6: private group registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      private_select_reg <= 32'h0000_0000;
      private_modifier_reg <= 32'h0000_0000;
    end else if (write_access && !ns_blocked) begin
      if (paddr == `OFS_PRIVATE_SELECT) begin
        private_select_reg <= pwdata;
      end
      if (paddr == `OFS_PRIVATE_MODIFIER) begin
        private_modifier_reg <= pwdata;
      end
    end
  end

  // R5: shared group arrays
  for (genvar n = 1; n < NUM_SPI_WORDS; n++) begin : g_spi_word
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        spi_select_reg[n] <= 32'h0000_0000;
        spi_modifier_reg[n] <= 32'h0000_0000;
      end else if (write_access && !ns_blocked && int'(word_idx) == n) begin
        if (paddr[11:7] == `SPI_SELECT_REGION) begin
          spi_select_reg[n] <= pwdata;
        end
        if (paddr[11:7] == `SPI_MODIFIER_REGION) begin
          spi_modifier_reg[n] <= pwdata;
        end
      end
    end
  end

  // Software interrupt permission
  always_comb begin
    sgi_group = GROUP_0;
    if (pwdata[5:4] == 2'h1) begin
      sgi_group = security_disable ? GROUP_1_NONSECURE : GROUP_1_SECURE;
    end else if (pwdata[5:4] == 2'h2) begin
      sgi_group = GROUP_1_NONSECURE;
    end
    // R14: no access control check
    if (security_disable || !nonsecure_req) begin
      sgi_allowed = 1'b1;
    // R13: state and access control
    end else begin
      case (sgi_group)
        GROUP_0: sgi_allowed = ns_access_reg[0];
        GROUP_1_SECURE: sgi_allowed = ns_access_reg[1];
        GROUP_1_NONSECURE: sgi_allowed = 1'b1;
        default: sgi_allowed = 1'b0;
      endcase
    end
  end

  // R8: acknowledge and completion events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= '0;
      completion_reg <= '0;
      sgi_reg <= '0;
    end else if (clk_en) begin
      ack_reg.valid <= 1'b0;
      completion_reg.valid <= 1'b0;
      sgi_reg.valid <= 1'b0;
      if (read_access && (paddr == `OFS_ACK_GRP0 || paddr == `OFS_ACK_GRP1)
          && rdata_reg[9:0] != `SPURIOUS_ID) begin
        ack_reg <= '{valid: 1'b1, grp: ack_group_reg, id: rdata_reg[9:0]};
      end
      // R15: priority drop check
      if (write_access && paddr == `OFS_DONE_GRP0 && !ns_blocked) begin
        completion_reg <= '{valid: 1'b1, grp: GROUP_0, id: pwdata[9:0]};
      end
      if (write_access && paddr == `OFS_DONE_GRP1) begin
        completion_reg <= '{valid: 1'b1, id: pwdata[9:0],
          grp: (nonsecure_req || security_disable) ? GROUP_1_NONSECURE : GROUP_1_SECURE};
      end
      if (write_access && paddr == `OFS_SGI_REQUEST && sgi_allowed) begin
        sgi_reg <= '{valid: 1'b1, grp: sgi_group, id: {6'h00, pwdata[3:0]}};
      end
    end
  end

endmodule

// ==== sim/intgrp_checker.sv ====
`timescale 1ns/1ps
module intgrp_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt side
  input wire intgrp_pkg::pending_type pending_in,
  input wire logic fast_interrupt_request,
  input wire logic normal_interrupt_request,
  input wire intgrp_pkg::event_type ack_event,
  input wire intgrp_pkg::event_type completion_event,
  input wire intgrp_pkg::event_type sgi_event
);
  import intgrp_pkg::*;
  logic ack_q;
  logic done_q;
  logic sgi_q;
  wire acc = psel && penable && pready;
  // Which access completed at the last enabled edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      done_q <= 1'b0;
      sgi_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= acc && !pwrite && (paddr inside {12'h020, 12'h024});
      done_q <= acc && pwrite && (paddr inside {12'h028, 12'h02C});
      sgi_q <= acc && pwrite && paddr == 12'h038;
    end
  end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ACTIVE_PENDING: assert property (clk_en && pending_in.active_pending |=>
    !fast_interrupt_request && !normal_interrupt_request) else $error("active pending signalled");
  AST_IDLE: assert property (clk_en && !pending_in.valid |=>
    !fast_interrupt_request && !normal_interrupt_request) else $error("request with nothing pending");
  AST_FREEZE: assert property (!clk_en |=>
    $stable(fast_interrupt_request) && $stable(normal_interrupt_request)) else $error("lines moved");
  AST_ONE_LINE: assert property (!(fast_interrupt_request && normal_interrupt_request))
    else $error("both lines high");
  AST_ACK_CAUSE: assert property (ack_event.valid |-> ack_q)
    else $error("ack event without read");
  AST_ACK_PULSE: assert property (clk_en && ack_event.valid |=> !ack_event.valid)
    else $error("ack event too long");
  AST_DONE_CAUSE: assert property (completion_event.valid |-> done_q)
    else $error("completion without write");
  AST_SGI_CAUSE: assert property (sgi_event.valid |-> sgi_q)
    else $error("sgi without write");
  AST_SHARED_INDEX: assert property (psel && penable && paddr == 12'h100 |-> pslverr)
    else $error("shared word zero accepted");
  COV_FAST: cover property ($rose(fast_interrupt_request));
  COV_NORMAL: cover property ($rose(normal_interrupt_request));
  COV_SGI: cover property (sgi_event.valid);
endmodule

bind interrupt_group_fiq_irq_select intgrp_checker checker_i (.*);

// ==== sim/pe_core_model.sv ====
`timescale 1ns/1ps
module pe_core_model (
  // Clock and request lines
  input wire logic pclk,
  input wire logic fast_interrupt_request,
  input wire logic normal_interrupt_request,
  // Context
  output intgrp_pkg::context_type pe_context,
  output logic context_sync,
  output logic [7:0] running_priority
);
  import intgrp_pkg::*;
  initial begin
    pe_context = '{2'h3, 1'b0};
    context_sync = 1'b0;
    running_priority = 8'hFF;
  end
  task automatic take_exception(input logic [1:0] lvl, input logic ns);
    pe_context <= '{lvl, ns};
    context_sync <= 1'b1;
    @(posedge pclk);
    context_sync <= 1'b0;
  endtask
  // Priority of the handler now running
  task automatic set_running(input logic [7:0] p);
    running_priority <= p;
  endtask
endmodule

// ==== sim/interrupt_group_fiq_irq_select_bench.sv ====
`timescale 1ns/1ps
module interrupt_group_fiq_irq_select_bench;
  import intgrp_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, context_sync, err;
  logic fast_interrupt_request, normal_interrupt_request;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] pprot;
  logic [7:0] running_priority;
  pending_type pending_in;
  context_type pe_context;
  event_type ack_event, completion_event, sgi_event;
  int mismatches = 0;
  int samples_checked = 0;

  interrupt_group_fiq_irq_select DUT (.*);
  pe_core_model pe (.*);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic ns);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pprot <= {1'b0, ns, 1'b0};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic lines(input string nm, input logic f, input logic n);
    repeat (2) @(posedge pclk);
    check(nm, {30'h0, fast_interrupt_request, normal_interrupt_request}, {30'h0, f, n});
  endtask

  // Fast-line pattern over secure level 1, nonsecure level 1, top level
  task automatic row(input string nm, input logic [9:0] id, input logic loc, input logic [31:0] ps,
                     input logic [31:0] pm, input logic [31:0] ss, input logic [2:0] fa);
    apb(1'b1, 12'h080, ps, 1'b0);
    apb(1'b1, 12'h084, pm, 1'b0);
    apb(1'b1, 12'h104, ss, 1'b0);
    pending_in <= '{1'b1, 1'b0, loc, id, 8'h10};
    for (int i = 0; i < 3; i++) begin
      pe.take_exception(i == 2 ? 2'h3 : 2'h1, i == 1);
      lines(nm, fa[2 - i], !fa[2 - i]);
    end
  endtask

  task automatic test_registers();
    apb(1'b0, 12'h000, 32'h0, 1'b0);
    check("ctrl reset", rd, 32'h0000_0050);
    apb(1'b1, 12'h000, 32'h0000_0051, 1'b1);
    apb(1'b0, 12'h000, 32'h0, 1'b0);
    check("ctrl ns write", rd, 32'h0000_0050);
    apb(1'b0, 12'h100, 32'h0, 1'b0);
    check("word0 err", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h104, 32'h0, 1'b0);
    check("word1 err", {31'h0, err}, 32'h0);
    $display("registers done");
  endtask

  task automatic test_groups();
    row("g0", 10'd5, 1'b0, 32'h0, 32'h0, 32'h0, 3'b111);
    row("ns g1", 10'd5, 1'b0, 32'h20, 32'h0, 32'h0, 3'b101);
    row("s g1", 10'd5, 1'b0, 32'h0, 32'h20, 32'h0, 3'b011);
    row("shared", 10'd40, 1'b0, 32'h0, 32'h0, 32'h100, 3'b101);
    row("local", 10'd5, 1'b1, 32'h0, 32'h0, 32'h0, 3'b101);
    apb(1'b1, 12'h000, 32'h70, 1'b0);
    row("t32 s g1", 10'd5, 1'b0, 32'h0, 32'h20, 32'h0, 3'b010);
    row("t32 ns g1", 10'd5, 1'b0, 32'h20, 32'h0, 32'h0, 3'b101);
    apb(1'b1, 12'h000, 32'h40, 1'b0);
    row("no sysreg", 10'd5, 1'b0, 32'h0, 32'h20, 32'h0, 3'b111);
    $display("groups done");
  endtask

  task automatic test_quiet();
    apb(1'b1, 12'h000, 32'h50, 1'b0);
    apb(1'b1, 12'h084, 32'h0, 1'b0);
    pending_in <= '{1'b1, 1'b1, 1'b0, 10'd5, 8'h10};
    lines("act pend", 1'b0, 1'b0);
    apb(1'b1, 12'h000, 32'h10, 1'b0);
    pending_in.active_pending <= 1'b0;
    lines("no affinity", 1'b0, 1'b0);
    apb(1'b1, 12'h000, 32'h50, 1'b0);
    clk_en <= 1'b0;
    pending_in.valid <= 1'b0;
    lines("frozen", 1'b1, 1'b0);
    clk_en <= 1'b1;
    lines("idle", 1'b0, 1'b0);
    $display("quiet done");
  endtask

  task automatic test_events();
    pending_in <= '{1'b1, 1'b0, 1'b0, 10'd5, 8'h10};
    apb(1'b0, 12'h020, 32'h0, 1'b0);
    check("ack0 id", rd, 32'h5);
    check("ack0 ev", {19'h0, ack_event}, {19'h0, 1'b1, GROUP_0, 10'd5});
    apb(1'b0, 12'h024, 32'h0, 1'b0);
    check("ack1 id", rd, 32'h3FF);
    apb(1'b0, 12'h030, 32'h0, 1'b0);
    check("high0", rd, 32'h5);
    apb(1'b1, 12'h028, 32'h5, 1'b0);
    check("done0 ev", {19'h0, completion_event}, {19'h0, 1'b1, GROUP_0, 10'd5});
    apb(1'b1, 12'h028, 32'h5, 1'b1);
    check("done0 ns", {31'h0, completion_event.valid}, 32'h0);
    apb(1'b1, 12'h03C, 32'h0, 1'b0);
    apb(1'b1, 12'h038, 32'h3, 1'b1);
    check("sgi refused", {31'h0, sgi_event.valid}, 32'h0);
    apb(1'b1, 12'h03C, 32'h1, 1'b0);
    apb(1'b1, 12'h038, 32'h3, 1'b1);
    check("sgi allowed", {19'h0, sgi_event}, {19'h0, 1'b1, GROUP_0, 10'd3});
    apb(1'b1, 12'h03C, 32'h0, 1'b0);
    apb(1'b1, 12'h000, 32'h51, 1'b0);
    apb(1'b1, 12'h038, 32'h3, 1'b1);
    check("sgi one state", {19'h0, sgi_event}, {19'h0, 1'b1, GROUP_0, 10'd3});
    $display("events done");
  endtask

  task automatic test_single();
    row("1s g0", 10'd5, 1'b0, 32'h0, 32'h0, 32'h0, 3'b111);
    row("1s g1", 10'd5, 1'b0, 32'h20, 32'h0, 32'h0, 3'b000);
    row("1s local", 10'd5, 1'b1, 32'h0, 32'h0, 32'h0, 3'b000);
    $display("single done");
  endtask

  task automatic test_binary_point();
    pe.set_running(8'h18);
    pending_in <= '{1'b1, 1'b0, 1'b0, 10'd5, 8'h10};
    apb(1'b1, 12'h080, 32'h20, 1'b0);
    apb(1'b1, 12'h00C, 32'h4, 1'b1);
    lines("bp g1", 1'b0, 1'b0);
    apb(1'b1, 12'h000, 32'h53, 1'b0);
    lines("common bp", 1'b0, 1'b1);
    apb(1'b1, 12'h000, 32'h58, 1'b0);
    lines("common s only", 1'b0, 1'b0);
    apb(1'b1, 12'h000, 32'h54, 1'b0);
    lines("common ns", 1'b1, 1'b0);
    apb(1'b0, 12'h024, 32'h0, 1'b1);
    check("ack1 ns id", rd, 32'h5);
    check("ack1 ns ev", {19'h0, ack_event}, {19'h0, 1'b1, GROUP_1_NONSECURE, 10'd5});
    $display("binary point done");
  endtask

  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pprot = 3'h0;
    pending_in = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 12'h004, 32'h7, 1'b0);
    apb(1'b1, 12'h010, 32'h80, 1'b0);
    test_registers();
    test_groups();
    test_quiet();
    test_events();
    test_single();
    test_binary_point();
    complete_run();
  end
endmodule
